//--- rtl/psb_pkg.sv
// shared constants for the secondary-bus side of the bridge
package psb_pkg;
    localparam int         NUM_REQ        = 9;
    localparam int         AD_W           = 32;
    localparam int         CBE_W          = 4;
    // configuration offsets and fields
    localparam logic [7:0] CMD_CTRL_OFF   = 8'h04;
    localparam logic [7:0] BRG_CTRL_OFF   = 8'h3e;
    localparam int         CMD_PERR_EN    = 6;
    localparam int         BRG_SERR_FWD   = 1;
    localparam int         BRG_ARB_DIS    = 15;
    localparam logic [15:0] CMD_CTRL_RST  = 16'h0000;
    localparam logic [15:0] BRG_CTRL_RST  = 16'h0000;
    // software register word offsets (word addresses, one register per address)
    localparam logic [3:0] SW_CMD_OFF     = 4'h0;
    localparam logic [3:0] SW_BRG_OFF     = 4'h4;
    localparam logic [3:0] SW_STAT_OFF    = 4'h8;
    localparam logic [3:0] SW_MASK_OFF    = 4'hc;
    // status bit positions
    localparam int         ST_PERR        = 0;
    localparam int         ST_SERR        = 1;
    localparam int         ST_STOP        = 2;
    localparam int         ST_DONE        = 3;
    localparam int         ST_W           = 4;
    typedef enum logic [1:0] {
        PSB_IDLE = 2'b00,
        PSB_ADDR = 2'b01,
        PSB_DATA = 2'b10,
        PSB_TURN = 2'b11
    } psb_state_e;
endpackage : psb_pkg

//--- rtl/psb_if.sv
// secondary bus wires joining the bridge end and a secondary agent end
`timescale 1ns/1ps
interface psb_if;
    logic [31:0] ad_bridge;
    logic        ad_bridge_oe;
    logic [31:0] ad_agent;
    logic        ad_agent_oe;
    logic [3:0]  cbe_bridge;
    logic        cbe_bridge_oe;
    logic [3:0]  cbe_agent;
    logic        cbe_agent_oe;
    logic        frame_n_bridge, frame_n_bridge_oe, frame_n_agent, frame_n_agent_oe;
    logic        irdy_n_bridge, irdy_n_bridge_oe, irdy_n_agent, irdy_n_agent_oe;
    logic        trdy_n_bridge, trdy_n_bridge_oe, trdy_n_agent, trdy_n_agent_oe;
    logic        stop_n_agent, stop_n_agent_oe;
    logic        lock_n_bridge, lock_n_bridge_oe;
    logic        par_bridge, par_bridge_oe, par_agent, par_agent_oe;
    logic        perr_n_bridge, perr_n_bridge_oe, perr_n_agent, perr_n_agent_oe;
    logic        serr_n_agent, serr_n_agent_oe;
    logic [8:0]  req_n;
    logic [8:0]  gnt_n;
    // resolved wire levels, pulled up when nobody drives, except ad and par which read zero
    wire [31:0] ad      = ad_bridge_oe ? ad_bridge : (ad_agent_oe ? ad_agent : 32'h0000_0000);
    wire [3:0]  cbe     = cbe_bridge_oe ? cbe_bridge : (cbe_agent_oe ? cbe_agent : 4'hf);
    wire frame_n = frame_n_bridge_oe ? frame_n_bridge : (frame_n_agent_oe ? frame_n_agent : 1'b1);
    wire irdy_n  = irdy_n_bridge_oe ? irdy_n_bridge : (irdy_n_agent_oe ? irdy_n_agent : 1'b1);
    wire trdy_n  = trdy_n_bridge_oe ? trdy_n_bridge : (trdy_n_agent_oe ? trdy_n_agent : 1'b1);
    wire stop_n  = stop_n_agent_oe ? stop_n_agent : 1'b1;
    wire lock_n  = lock_n_bridge_oe ? lock_n_bridge : 1'b1;
    wire par     = par_bridge_oe ? par_bridge : (par_agent_oe ? par_agent : 1'b0);
    wire perr_n  = perr_n_bridge_oe ? perr_n_bridge : (perr_n_agent_oe ? perr_n_agent : 1'b1);
    wire serr_n  = serr_n_agent_oe ? serr_n_agent : 1'b1;
    modport bridge (
        input  ad, cbe, frame_n, irdy_n, trdy_n, stop_n, par, perr_n, serr_n, req_n,
        output ad_bridge, ad_bridge_oe, cbe_bridge, cbe_bridge_oe,
        output frame_n_bridge, frame_n_bridge_oe, irdy_n_bridge, irdy_n_bridge_oe,
        output trdy_n_bridge, trdy_n_bridge_oe, lock_n_bridge, lock_n_bridge_oe,
        output par_bridge, par_bridge_oe, perr_n_bridge, perr_n_bridge_oe, gnt_n
    );
    modport agent (
        input  ad, cbe, frame_n, irdy_n, trdy_n, par, perr_n, gnt_n,
        output ad_agent, ad_agent_oe, cbe_agent, cbe_agent_oe,
        output frame_n_agent, frame_n_agent_oe, irdy_n_agent, irdy_n_agent_oe,
        output trdy_n_agent, trdy_n_agent_oe, stop_n_agent, stop_n_agent_oe,
        output par_agent, par_agent_oe, perr_n_agent, perr_n_agent_oe,
        output serr_n_agent, serr_n_agent_oe, req_n
    );
endinterface : psb_if

//--- rtl/psb_bridge.sv
// bridge end: secondary master for writes, target for reads, arbiter, registers
// Notes on behaviour
// - data phase ends when both ready lines low
// - even parity over address/data and byte enables
// - master write parity driven one clock later
// - read target compares parity, may flag error
// - parity error reported only when command enables
// - masters request via own request input
// - arbiter off: request zero is our grant
// - arbiter off: grant zero carries our request
// - system error forwarded only when enabled
// - system error line never driven by bridge
// - stop from target ends the transaction
// - lock line gives exclusive bus access; here only driven low during a locked write, arbiter ignores it
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
module psb_bridge (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    // avalon-mm slave
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    // primary side
    output logic             o_pri_serr,
    output logic             o_irq,
    // secondary bus
    psb_if.bridge            sb
);
    localparam int N = psb_pkg::NUM_REQ;

    logic [15:0] cmd_reg, brg_reg;
    logic [psb_pkg::ST_W-1:0] stat_reg, mask_reg, ev;
    logic [31:0] wr_addr_reg, wr_data_reg;
    logic        wr_go_reg, wr_lock_reg;
    logic        wreq_reg;
    logic [31:0] rd_reg;
    psb_pkg::psb_state_e st_reg;
    logic [N-1:0] gnt_n_reg;
    logic        own_gnt_reg;
    logic        pend_par_reg, chk_reg, chk_par_reg;
    logic        serr_reg, irq_reg;
    logic [31:0] ad_o_reg;
    logic        ad_oe_reg, frame_reg, irdy_reg, mst_oe_reg, par_o_reg, par_oe_reg;
    logic        trdy_reg, trdy_oe_reg, perr_reg, perr_oe_reg, lock_reg;
    logic        tgt_reg;

    wire arb_dis  = brg_reg[psb_pkg::BRG_ARB_DIS];
    wire perr_en  = cmd_reg[psb_pkg::CMD_PERR_EN];
    wire phase_ok = !sb.irdy_n && !sb.trdy_n;
    wire my_gnt   = arb_dis ? !sb.req_n[0] : own_gnt_reg;
    wire bus_idle = sb.frame_n && sb.irdy_n;
    wire par_calc = ^{sb.ad, sb.cbe};
    wire sel_wr   = i_avs_write && !wreq_reg;
    wire sel_rd   = i_avs_read && !wreq_reg;

    // avalon slave: one wait cycle, writes land where waitrequest is low
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            wreq_reg <= 1'b1;
            rd_reg   <= 32'h0000_0000;
        end else begin
            wreq_reg <= !((i_avs_read || i_avs_write) && wreq_reg);
            unique case (i_avs_address)
                psb_pkg::SW_CMD_OFF:  rd_reg <= {16'h0000, cmd_reg};
                psb_pkg::SW_BRG_OFF:  rd_reg <= {16'h0000, brg_reg};
                psb_pkg::SW_STAT_OFF: rd_reg <= {28'h0000000, stat_reg};
                psb_pkg::SW_MASK_OFF: rd_reg <= {28'h0000000, mask_reg};
                default:              rd_reg <= {31'h00000000, st_reg == psb_pkg::PSB_IDLE};
            endcase
        end
    end
    assign o_avs_readdata    = rd_reg;
    assign o_avs_waitrequest = wreq_reg;

    // configuration registers and write command
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            cmd_reg     <= psb_pkg::CMD_CTRL_RST;
            brg_reg     <= psb_pkg::BRG_CTRL_RST;
            mask_reg    <= '0;
            wr_addr_reg <= 32'h0000_0000;
            wr_data_reg <= 32'h0000_0000;
            wr_lock_reg <= 1'b0;
        end else if (sel_wr) begin
            unique case (i_avs_address)
                psb_pkg::SW_CMD_OFF:  cmd_reg <= i_avs_writedata[15:0];
                psb_pkg::SW_BRG_OFF:  brg_reg <= i_avs_writedata[15:0];
                psb_pkg::SW_MASK_OFF: mask_reg <= i_avs_writedata[psb_pkg::ST_W-1:0];
                4'h1: wr_addr_reg <= i_avs_writedata;
                4'h2: wr_data_reg <= i_avs_writedata;
                4'h3: wr_lock_reg <= i_avs_writedata[0];
                default: ;
            endcase
        end
    end

    // go flag: set by software, cleared on start
    always_ff @(posedge i_clk) begin
        if (!i_resetn) wr_go_reg <= 1'b0;
        else if (sel_wr && i_avs_address == 4'h3) wr_go_reg <= 1'b1;
        else if (st_reg == psb_pkg::PSB_ADDR) wr_go_reg <= 1'b0;
    end

    // internal arbiter, fixed priority, single grant
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            gnt_n_reg   <= '1;
            own_gnt_reg <= 1'b0;
        end else if (arb_dis) begin
            gnt_n_reg   <= {{(N-1){1'b1}}, !wr_go_reg};
            own_gnt_reg <= 1'b0;
        end else if (bus_idle && st_reg == psb_pkg::PSB_IDLE) begin
            gnt_n_reg   <= '1;
            own_gnt_reg <= 1'b0;
            if (wr_go_reg) own_gnt_reg <= 1'b1;
            else begin
                for (int i = N - 1; i >= 0; i--) begin
                    if (!sb.req_n[i]) gnt_n_reg <= ~(N'(1) << i);
                end
            end
        end
    end
    assign sb.gnt_n = gnt_n_reg;

    // master write sequencer
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            st_reg     <= psb_pkg::PSB_IDLE;
            ad_o_reg   <= 32'h0000_0000;
            ad_oe_reg  <= 1'b0;
            frame_reg  <= 1'b1;
            irdy_reg   <= 1'b1;
            mst_oe_reg <= 1'b0;
            lock_reg   <= 1'b1;
        end else begin
            unique case (st_reg)
                psb_pkg::PSB_IDLE: if (wr_go_reg && my_gnt && bus_idle) begin
                    st_reg     <= psb_pkg::PSB_ADDR;
                    ad_o_reg   <= wr_addr_reg;
                    ad_oe_reg  <= 1'b1;
                    frame_reg  <= 1'b0;
                    mst_oe_reg <= 1'b1;
                    lock_reg   <= !wr_lock_reg;
                end
                psb_pkg::PSB_ADDR: begin
                    st_reg    <= psb_pkg::PSB_DATA;
                    ad_o_reg  <= wr_data_reg;
                    frame_reg <= 1'b1;
                    irdy_reg  <= 1'b0;
                end
                psb_pkg::PSB_DATA: if (phase_ok || !sb.stop_n) begin
                    st_reg    <= psb_pkg::PSB_TURN;
                    irdy_reg  <= 1'b1;
                    ad_oe_reg <= 1'b0;
                end
                psb_pkg::PSB_TURN: begin
                    st_reg     <= psb_pkg::PSB_IDLE;
                    mst_oe_reg <= 1'b0;
                    lock_reg   <= 1'b1;
                end
            endcase
        end
    end

    // parity out one clock behind covered phase
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            par_o_reg  <= 1'b0;
            par_oe_reg <= 1'b0;
        end else begin
            par_oe_reg <= ad_oe_reg;
            par_o_reg  <= par_calc;
        end
    end

    // read target: answer reads with write data, check master parity
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            tgt_reg     <= 1'b0;
            trdy_reg    <= 1'b1;
            trdy_oe_reg <= 1'b0;
            chk_reg     <= 1'b0;
            chk_par_reg <= 1'b0;
            perr_reg    <= 1'b1;
            perr_oe_reg <= 1'b0;
        end else begin
            if (!sb.frame_n && sb.irdy_n && !mst_oe_reg && sb.cbe == 4'h6) begin
                tgt_reg     <= 1'b1;
                trdy_oe_reg <= 1'b1;
            end else if (tgt_reg && phase_ok) begin
                tgt_reg  <= 1'b0;
                trdy_reg <= 1'b1;
            end else if (tgt_reg) trdy_reg <= 1'b0;
            else trdy_oe_reg <= 1'b0;
            chk_reg     <= !mst_oe_reg && (!sb.frame_n || phase_ok);
            chk_par_reg <= par_calc;
            perr_reg    <= !(chk_reg && perr_en && chk_par_reg != sb.par);
            perr_oe_reg <= chk_reg && perr_en;
        end
    end

    // status events, set beats clear
    assign ev[psb_pkg::ST_PERR] = !perr_reg;
    assign ev[psb_pkg::ST_SERR] = !sb.serr_n;
    assign ev[psb_pkg::ST_STOP] = st_reg == psb_pkg::PSB_DATA && !sb.stop_n;
    assign ev[psb_pkg::ST_DONE] = st_reg == psb_pkg::PSB_TURN;
    always_ff @(posedge i_clk) begin
        if (!i_resetn) stat_reg <= '0;
        else if (sel_wr && i_avs_address == psb_pkg::SW_STAT_OFF)
            stat_reg <= (stat_reg & ~i_avs_writedata[psb_pkg::ST_W-1:0]) | ev;
        else stat_reg <= stat_reg | ev;
    end

    // primary forwarding and interrupt
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            serr_reg <= 1'b0;
            irq_reg  <= 1'b0;
        end else begin
            serr_reg <= !sb.serr_n && brg_reg[psb_pkg::BRG_SERR_FWD];
            irq_reg  <= |(stat_reg & mask_reg);
        end
    end
    assign o_pri_serr = serr_reg;
    assign o_irq      = irq_reg;

    assign sb.ad_bridge         = tgt_reg ? wr_data_reg : ad_o_reg;
    assign sb.ad_bridge_oe      = ad_oe_reg || (tgt_reg && !sel_rd && trdy_oe_reg);
    assign sb.cbe_bridge        = (st_reg == psb_pkg::PSB_ADDR) ? 4'h7 : 4'h0;
    assign sb.cbe_bridge_oe     = ad_oe_reg;
    assign sb.frame_n_bridge    = frame_reg;
    assign sb.frame_n_bridge_oe = mst_oe_reg;
    assign sb.irdy_n_bridge     = irdy_reg;
    assign sb.irdy_n_bridge_oe  = mst_oe_reg;
    assign sb.trdy_n_bridge     = trdy_reg;
    assign sb.trdy_n_bridge_oe  = trdy_oe_reg;
    assign sb.lock_n_bridge     = lock_reg;
    assign sb.lock_n_bridge_oe  = mst_oe_reg;
    assign sb.par_bridge        = par_o_reg;
    assign sb.par_bridge_oe     = par_oe_reg;
    assign sb.perr_n_bridge     = perr_reg;
    assign sb.perr_n_bridge_oe  = perr_oe_reg;
endmodule : psb_bridge

//--- rtl/psb_agent.sv
// secondary agent end: requests bus, target of bridge writes, reports errors
`timescale 1ns/1ps
module psb_agent (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    // user side
    input  wire logic        i_req,
    input  wire logic        i_stop,
    input  wire logic        i_serr,
    input  wire logic        i_perr_en,
    output logic             o_gnt,
    output logic             o_wr_valid,
    output logic      [31:0] o_wr_data,
    output logic             o_perr,
    // secondary bus
    psb_if.agent             sb
);
    logic        gnt_reg, wv_reg, perr_reg, in_reg, chk_reg, cpar_reg;
    logic [31:0] wd_reg;
    logic        trdy_reg, trdy_oe_reg, stop_reg, perr_n_reg, perr_oe_reg;

    wire phase_ok = !sb.irdy_n && !sb.trdy_n;

    // target of bridge write; stop ends it early
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            in_reg      <= 1'b0;
            trdy_reg    <= 1'b1;
            trdy_oe_reg <= 1'b0;
            stop_reg    <= 1'b1;
            wv_reg      <= 1'b0;
            wd_reg      <= 32'h0000_0000;
        end else begin
            wv_reg <= 1'b0;
            if (!sb.frame_n && sb.irdy_n && sb.cbe == 4'h7) begin
                in_reg      <= 1'b1;
                trdy_oe_reg <= 1'b1;
            end else if (in_reg && (phase_ok || !stop_reg)) begin
                in_reg   <= 1'b0;
                trdy_reg <= 1'b1;
                stop_reg <= 1'b1;
                wv_reg   <= phase_ok;
                wd_reg   <= sb.ad;
            end else if (in_reg) begin
                trdy_reg <= i_stop;
                stop_reg <= !i_stop;
            end else trdy_oe_reg <= 1'b0;
        end
    end

    // parity check of observed phases
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            chk_reg     <= 1'b0;
            cpar_reg    <= 1'b0;
            perr_n_reg  <= 1'b1;
            perr_oe_reg <= 1'b0;
            perr_reg    <= 1'b0;
            gnt_reg     <= 1'b0;
        end else begin
            chk_reg     <= in_reg && phase_ok;
            cpar_reg    <= ^{sb.ad, sb.cbe};
            perr_n_reg  <= !(chk_reg && i_perr_en && cpar_reg != sb.par);
            perr_oe_reg <= chk_reg && i_perr_en;
            perr_reg    <= !sb.perr_n;
            gnt_reg     <= !sb.gnt_n[0];
        end
    end

    assign o_gnt       = gnt_reg;
    assign o_wr_valid  = wv_reg;
    assign o_wr_data   = wd_reg;
    assign o_perr      = perr_reg;
    assign sb.req_n    = {8'hff, !i_req};
    assign sb.ad_agent = 32'h0000_0000;
    assign sb.ad_agent_oe      = 1'b0;
    assign sb.cbe_agent        = 4'hf;
    assign sb.cbe_agent_oe     = 1'b0;
    assign sb.frame_n_agent    = 1'b1;
    assign sb.frame_n_agent_oe = 1'b0;
    assign sb.irdy_n_agent     = 1'b1;
    assign sb.irdy_n_agent_oe  = 1'b0;
    assign sb.trdy_n_agent     = trdy_reg;
    assign sb.trdy_n_agent_oe  = trdy_oe_reg;
    assign sb.stop_n_agent     = stop_reg;
    assign sb.stop_n_agent_oe  = trdy_oe_reg;
    assign sb.par_agent        = 1'b0;
    assign sb.par_agent_oe     = 1'b0;
    assign sb.perr_n_agent     = perr_n_reg;
    assign sb.perr_n_agent_oe  = perr_oe_reg;
    assign sb.serr_n_agent     = !i_serr;
    assign sb.serr_n_agent_oe  = i_serr;
endmodule : psb_agent

//--- test/psb_asserts.sv
// concurrent checks on the secondary bus wires
`timescale 1ns/1ps
module psb_asserts (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    // resolved wires
    input  wire logic [31:0] ad,
    input  wire logic [3:0]  cbe,
    input  wire logic        irdy_n,
    input  wire logic        trdy_n,
    input  wire logic        stop_n,
    input  wire logic        par,
    input  wire logic        serr_n,
    input  wire logic [8:0]  gnt_n,
    // drive enables
    input  wire logic        ad_bridge_oe,
    input  wire logic        par_bridge_oe,
    input  wire logic        irdy_n_bridge_oe,
    input  wire logic        trdy_n_bridge_oe,
    input  wire logic        serr_n_agent_oe
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    a_one_grant: assert property ($countones(~gnt_n) <= 1)
        else $error("more than one grant low");
    a_par_even_lag: assert property (ad_bridge_oe |=>
        par_bridge_oe && (par == ^{$past(ad), $past(cbe)})) else $error("bad parity");
    a_irdy_wait_hold: assert property (irdy_n_bridge_oe && !irdy_n && trdy_n && stop_n
        |=> !irdy_n) else $error("initiator ready dropped in wait");
    a_ad_wait_stable: assert property (irdy_n_bridge_oe && !irdy_n && trdy_n && stop_n
        |=> $stable(ad)) else $error("data moved in wait state");
    a_trdy_wait_hold: assert property (trdy_n_bridge_oe && !trdy_n && irdy_n
        |=> !trdy_n) else $error("target ready dropped in wait");
    a_phase_end_release: assert property (irdy_n_bridge_oe && !irdy_n && !trdy_n
        |=> irdy_n) else $error("single phase not ended");
    a_stop_ends_cycle: assert property (irdy_n_bridge_oe && !irdy_n && !stop_n
        |=> ##[0:3] irdy_n) else $error("stop ignored by master");
    a_serr_not_driven: assert property (!serr_n_agent_oe |-> serr_n)
        else $error("system error line driven by bridge");
endmodule : psb_asserts

//--- test/tb.sv
// self-checking bench joining the bridge end and the agent end
`timescale 1ns/1ps
module tb;
    logic        i_clk;
    logic        i_resetn;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        pri_serr;
    logic        irq;
    logic        a_req;
    logic        a_stop;
    logic        a_serr;
    logic        a_perr_en;
    logic        a_gnt;
    logic        wr_valid;
    logic [31:0] wr_data;
    logic        a_perr;
    logic [31:0] q;
    logic [31:0] d;
    int          failures;
    int          n_checks;
    int          k;

    psb_if u_psb_if ();
    psb_bridge u_psb_bridge (.i_clk(i_clk), .i_resetn(i_resetn), .i_avs_address(avs_address),
        .i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
        .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest),
        .o_pri_serr(pri_serr), .o_irq(irq), .sb(u_psb_if));
    psb_agent u_psb_agent (.i_clk(i_clk), .i_resetn(i_resetn), .i_req(a_req), .i_stop(a_stop),
        .i_serr(a_serr), .i_perr_en(a_perr_en), .o_gnt(a_gnt), .o_wr_valid(wr_valid),
        .o_wr_data(wr_data), .o_perr(a_perr), .sb(u_psb_if));
    psb_asserts u_psb_asserts (.i_clk(i_clk), .i_resetn(i_resetn), .ad(u_psb_if.ad),
        .cbe(u_psb_if.cbe), .irdy_n(u_psb_if.irdy_n), .trdy_n(u_psb_if.trdy_n),
        .stop_n(u_psb_if.stop_n), .par(u_psb_if.par), .serr_n(u_psb_if.serr_n),
        .gnt_n(u_psb_if.gnt_n), .ad_bridge_oe(u_psb_if.ad_bridge_oe),
        .par_bridge_oe(u_psb_if.par_bridge_oe), .irdy_n_bridge_oe(u_psb_if.irdy_n_bridge_oe),
        .trdy_n_bridge_oe(u_psb_if.trdy_n_bridge_oe),
        .serr_n_agent_oe(u_psb_if.serr_n_agent_oe));

    always #25 i_clk = ~i_clk;

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task end_sim;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    task av(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        int n;
        @(posedge i_clk);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= ~wr;
        avs_writedata <= wd;
        for (n = 0; n < 40; n++) begin
            @(posedge i_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (n == 40) begin
            chk(32'h0, 32'h1);
            end_sim();
        end
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : av

    // address, data, then go with lock in bit 0
    task send(input logic [31:0] wd, input logic lk);
        av(1'b1, 4'h1, $urandom);
        av(1'b1, 4'h2, wd);
        av(1'b1, 4'h3, {31'h0, lk});
    endtask : send

    task wait_wr(input logic [31:0] exp, input logic lk);
        int n;
        for (n = 0; n < 60; n++) begin
            @(posedge i_clk);
            if (wr_valid === 1'b1) break;
        end
        chk({31'h0, wr_valid}, 32'h1);
        chk(wr_data, exp);
        chk({31'h0, u_psb_if.lock_n}, {31'h0, !lk});
        if (wr_valid !== 1'b1) end_sim();
    endtask : wait_wr

    task poll(input int b);
        int n;
        for (n = 0; n < 20; n++) begin
            av(1'b0, psb_pkg::SW_STAT_OFF, 32'h0);
            if (q[b] === 1'b1) break;
        end
        chk({31'h0, q[b]}, 32'h1);
        if (q[b] !== 1'b1) end_sim();
    endtask : poll

    initial begin
        i_clk = 1'b0; i_resetn = 1'b0; avs_address = 4'h0; avs_read = 1'b0;
        avs_write = 1'b0; avs_writedata = 32'h0; a_req = 1'b0; a_stop = 1'b0;
        a_serr = 1'b0; a_perr_en = 1'b0; failures = 0; n_checks = 0;
        void'($urandom(32'h73b515c6));
        repeat (6) @(posedge i_clk);
        i_resetn <= 1'b1;
        for (int r = 0; r < 4; r++) begin
            av(1'b0, 4'(r * 4), 32'h0);
            chk(q, 32'h0);
        end
        chk({30'h0, pri_serr, irq}, 32'h0);
        av(1'b0, 4'h5, 32'h0);
        chk({31'h0, q[0]}, 32'h1);
        $display("test reset done");
        av(1'b1, psb_pkg::SW_MASK_OFF, 32'h8);
        for (int n = 0; n < 6; n++) begin
            d = (n == 0) ? 32'hffff_ffff : $urandom;
            send(d, n[0]);
            wait_wr(d, n[0]);
            poll(psb_pkg::ST_DONE);
            chk({31'h0, irq}, 32'h1);
            av(1'b1, psb_pkg::SW_STAT_OFF, 32'h8);
            av(1'b0, psb_pkg::SW_STAT_OFF, 32'h0);
            chk({28'h0, q[3:0]} & 32'h8, 32'h0);
            chk({31'h0, irq}, 32'h0);
        end
        $display("test writes done");
        a_stop <= 1'b1;
        send($urandom, 1'b0);
        poll(psb_pkg::ST_STOP);
        a_stop <= 1'b0;
        av(1'b1, psb_pkg::SW_STAT_OFF, 32'hc);
        $display("test stop done");
        a_req <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge i_clk);
            if (a_gnt === 1'b1) break;
        end
        chk({31'h0, a_gnt}, 32'h1);
        if (a_gnt !== 1'b1) end_sim();
        a_req <= 1'b0;
        repeat (4) @(posedge i_clk);
        $display("test arbiter done");
        av(1'b1, psb_pkg::SW_BRG_OFF, 32'h1 << psb_pkg::BRG_ARB_DIS);
        d = $urandom;
        send(d, 1'b0);
        for (k = 0; k < 6; k++) begin
            @(posedge i_clk);
            chk({31'h0, wr_valid}, 32'h0);
        end
        chk({31'h0, u_psb_if.gnt_n[0]}, 32'h0);
        a_req <= 1'b1;
        wait_wr(d, 1'b0);
        a_req <= 1'b0;
        av(1'b1, psb_pkg::SW_BRG_OFF, 32'h0);
        av(1'b1, psb_pkg::SW_STAT_OFF, 32'hf);
        $display("test external arbiter done");
        av(1'b1, psb_pkg::SW_MASK_OFF, 32'h0);
        a_serr <= 1'b1;
        poll(psb_pkg::ST_SERR);
        chk({30'h0, pri_serr, irq}, 32'h0);
        av(1'b1, psb_pkg::SW_MASK_OFF, 32'h2);
        av(1'b1, psb_pkg::SW_BRG_OFF, 32'h2);
        av(1'b0, psb_pkg::SW_BRG_OFF, 32'h0);
        chk({30'h0, pri_serr, irq}, 32'h3);
        a_serr <= 1'b0;
        av(1'b1, psb_pkg::SW_BRG_OFF, 32'h0);
        av(1'b1, psb_pkg::SW_STAT_OFF, 32'h2);
        av(1'b0, psb_pkg::SW_STAT_OFF, 32'h0);
        chk({30'h0, q[1], irq}, 32'h0);
        $display("test system error done");
        a_perr_en <= 1'b1;
        av(1'b1, psb_pkg::SW_CMD_OFF, 32'h40);
        d = $urandom;
        send(d, 1'b1);
        wait_wr(d, 1'b1);
        av(1'b0, psb_pkg::SW_STAT_OFF, 32'h0);
        chk({30'h0, q[0], a_perr}, 32'h0);
        $display("test parity enable done");
        end_sim();
    end
endmodule : tb
